// ==== rtl/rbt16_core.sv ====
// Purpose: Two-lane registered bus transceiver with capture log
// Assumes: Pins and capture clocks sampled synchronously to clk
// Notes: Driven outputs are registered, so live transfer lags one cycle
//
// Decided for this implementation: the Avalon-MM interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`default_nettype none

// Functional notes
// - Two independent byte lanes, own controls each
// - Capture rising edge loads port into register
// - Capture edges ignore enables and selects
// - Isolation drives nothing; registers still load on capture edges
// - A-to-B live: port B follows port A
// - A-to-B stored: port B shows A register
// - B-to-A live: port A follows port B
// - B-to-A stored: port A shows B register
// - Both driven, both stored: crossed stored values out
// - Stored A-to-B shows newly captured value
// - Stored B-to-A shows newly captured value
// - Live transfer continues while capturing input
// - Input storable in either or both registers
// - All transfers non-inverting
// - Both live enabled forms retaining loop
module rbt16_core (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Lane controls
    input wire rbt16_pkg::rbt16_ctl_t ctl,
    // Port A lines
    input wire logic [rbt16_pkg::WORD_W-1:0] port_a_in,
    output rbt16_pkg::rbt16_drv_t port_a_drv,
    // Port B lines
    input wire logic [rbt16_pkg::WORD_W-1:0] port_b_in,
    output rbt16_pkg::rbt16_drv_t port_b_drv,
    // Avalon-MM slave
    input wire logic [rbt16_pkg::ADDR_W-1:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [rbt16_pkg::DATA_W-1:0] avs_writedata,
    output logic [rbt16_pkg::DATA_W-1:0] avs_readdata,
    output logic avs_waitrequest
);
    import rbt16_pkg::*;

    localparam int CW = $clog2(FIFO_DEPTH+1);

    // ==========================================================
    // State
    typedef struct packed {
        logic [WORD_W-1:0] a_side_register;
        logic [WORD_W-1:0] b_side_register;
        logic [LANES-1:0] a_cap_q;
        logic [LANES-1:0] b_cap_q;
        rbt16_drv_t a_drv;
        rbt16_drv_t b_drv;
        logic waitrequest;
        logic ack;
        logic [DATA_W-1:0] readdata;
        logic log_enable;
        logic overflow;
    } rbt16_st_t;

    rbt16_st_t r;
    rbt16_st_t next_r;

    logic [LANES-1:0] a_rise;
    logic [LANES-1:0] b_rise;
    logic take;
    logic rd_take;
    logic wr_take;
    logic log_valid;
    logic log_ready;
    logic log_out_valid;
    logic log_pop;
    logic [LOG_W-1:0] log_in;
    logic [LOG_W-1:0] log_out;
    logic [CW-1:0] log_count;
    rbt16_log_t head;

    // ==========================================================
    // Helpers
    // Rising edge of a sampled capture clock
    function automatic logic [LANES-1:0] rise_of(
        input logic [LANES-1:0] cur,
        input logic [LANES-1:0] prev
    );
        return cur & ~prev;
    endfunction

    // Address hit for one register word
    function automatic logic hit(
        input logic [ADDR_W-1:0] addr,
        input logic [ADDR_W-1:0] off
    );
        return addr == off;
    endfunction

    // ==========================================================
    // Capture edges and bus request terms
    // ungated edge detect
    assign a_rise = rise_of(ctl.a_capture_clock, r.a_cap_q);
    assign b_rise = rise_of(ctl.b_capture_clock, r.b_cap_q);
    assign take = (avs_read || avs_write) && !r.ack;
    assign rd_take = take && avs_read;
    assign wr_take = take && avs_write;
    assign log_pop = rd_take && hit(avs_address, REG_LOG_DATA);
    assign head = rbt16_log_t'(log_out);

    // ==========================================================
    // Next-state logic
    always_comb begin
        next_r = r;
        next_r.a_cap_q = ctl.a_capture_clock;
        next_r.b_cap_q = ctl.b_capture_clock;
        for (int l = 0; l < LANES; l++) begin
            if (a_rise[l]) begin
                next_r.a_side_register[l*LANE_W +: LANE_W] =
                    port_a_in[l*LANE_W +: LANE_W];
            end
            if (b_rise[l]) begin
                next_r.b_side_register[l*LANE_W +: LANE_W] =
                    port_b_in[l*LANE_W +: LANE_W];
            end
            next_r.b_drv.drive[l] = ctl.a_to_b_drive_enable[l];
            next_r.a_drv.drive[l] = !ctl.b_to_a_drive_enable_low[l];
            next_r.b_drv.value[l*LANE_W +: LANE_W] =
                ctl.a_to_b_source_select[l] ?
                next_r.a_side_register[l*LANE_W +: LANE_W] :
                port_a_in[l*LANE_W +: LANE_W];
            next_r.a_drv.value[l*LANE_W +: LANE_W] =
                ctl.b_to_a_source_select[l] ?
                next_r.b_side_register[l*LANE_W +: LANE_W] :
                port_b_in[l*LANE_W +: LANE_W];
        end
        // both live drive back each other
        // Bus answer one cycle after the request is taken
        next_r.ack = take;
        next_r.waitrequest = !take;
        if (take) begin
            next_r.readdata = '0;
        end
        if (rd_take) begin
            unique case (1'b1)
                hit(avs_address, REG_CTRL): begin
                    next_r.readdata[CTRL_LOG_EN_BIT] = r.log_enable;
                end
                hit(avs_address, REG_STATUS): begin
                    next_r.readdata[STAT_EMPTY_BIT] = !log_out_valid;
                    next_r.readdata[STAT_FULL_BIT] = !log_ready;
                    next_r.readdata[STAT_OVF_BIT] = r.overflow;
                    next_r.readdata[STAT_COUNT_LSB +: CW] = log_count;
                end
                hit(avs_address, REG_STORE): begin
                    next_r.readdata = {r.b_side_register,
                                       r.a_side_register};
                end
                hit(avs_address, REG_LOG_DATA): begin
                    if (log_out_valid) begin
                        next_r.readdata = {head.b_word, head.a_word};
                    end
                end
                hit(avs_address, REG_LOG_MASK): begin
                    if (log_out_valid) begin
                        next_r.readdata[MASK_W-1:0] =
                            {head.b_mask, head.a_mask};
                    end
                end
                default: begin
                    next_r.readdata = '0;
                end
            endcase
        end
        // Control write and overflow clear
        if (wr_take && hit(avs_address, REG_CTRL)) begin
            next_r.log_enable = avs_writedata[CTRL_LOG_EN_BIT];
        end
        if (wr_take && hit(avs_address, REG_STATUS) &&
            avs_writedata[STAT_OVF_BIT]) begin
            next_r.overflow = 1'h0;
        end
        // Dropped entry sets overflow; set wins over clear
        if (log_valid && !log_ready) begin
            next_r.overflow = 1'h1;
        end
    end

    // ==========================================================
    // State register
    always_ff @(posedge clk) begin
        r <= next_r;
        if (rst) begin
            r.a_cap_q <= '0;
            r.b_cap_q <= '0;
            r.a_drv <= '0;
            r.b_drv <= '0;
            r.waitrequest <= RST_WAIT;
            r.ack <= 1'h0;
            r.readdata <= '0;
            r.log_enable <= RST_LOG_EN;
            r.overflow <= 1'h0;
        end
    end

    // ==========================================================
    // Capture log
    // Each cycle with a capture pushes one entry when enabled and the log is not full
    assign log_valid = r.log_enable && ((a_rise | b_rise) != '0);
    assign log_in = {b_rise, a_rise, next_r.b_side_register,
                     next_r.a_side_register};

    rbt16_fifo #(
        .WIDTH(LOG_W),
        .DEPTH(FIFO_DEPTH)
    ) u_log (
        .clk(clk),
        .rst(rst),
        .in_valid(log_valid),
        .in_ready(log_ready),
        .in_data(log_in),
        .out_valid(log_out_valid),
        .out_ready(log_pop),
        .out_data(log_out),
        .count(log_count)
    );

    // Outputs straight from flip-flops
    assign port_a_drv = r.a_drv;
    assign port_b_drv = r.b_drv;
    assign avs_readdata = r.readdata;
    assign avs_waitrequest = r.waitrequest;

    // ==========================================================
    // Checks
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (rst);

    for (genvar g = 0; g < LANES; g++) begin : g_chk
        localparam int LO = g * LANE_W;

        sequence s_ab_stored;
            ctl.a_to_b_drive_enable[g] && ctl.a_to_b_source_select[g];
        endsequence

        sequence s_ba_stored;
            !ctl.b_to_a_drive_enable_low[g] &&
            ctl.b_to_a_source_select[g];
        endsequence

        chk_a_capture_load: assert property (
            a_rise[g] |=> r.a_side_register[LO +: LANE_W] ==
                $past(port_a_in[LO +: LANE_W]))
            else $error("A register missed a capture");

        chk_hold_storage: assert property (
            !b_rise[g] |=> $stable(r.b_side_register[LO +: LANE_W]))
            else $error("B register changed without capture");

        chk_isolation_drive: assert property (
            !ctl.a_to_b_drive_enable[g] &&
            ctl.b_to_a_drive_enable_low[g]
            |=> !port_a_drv.drive[g] && !port_b_drv.drive[g])
            else $error("Port driven in isolation");

        chk_live_ab: assert property (
            ctl.a_to_b_drive_enable[g] &&
            ctl.b_to_a_drive_enable_low[g] &&
            !ctl.a_to_b_source_select[g]
            |=> port_b_drv.drive[g] && port_b_drv.value[LO +: LANE_W]
                == $past(port_a_in[LO +: LANE_W]))
            else $error("Port B not following port A");

        chk_live_ba: assert property (
            !ctl.a_to_b_drive_enable[g] &&
            !ctl.b_to_a_drive_enable_low[g] &&
            !ctl.b_to_a_source_select[g]
            |=> port_a_drv.drive[g] && port_a_drv.value[LO +: LANE_W]
                == $past(port_b_in[LO +: LANE_W]))
            else $error("Port A not following port B");

        chk_stored_ab: assert property (
            s_ab_stored |=> port_b_drv.value[LO +: LANE_W] ==
                r.a_side_register[LO +: LANE_W])
            else $error("Port B not showing A register");

        chk_stored_ba: assert property (
            s_ba_stored |=> port_a_drv.value[LO +: LANE_W] ==
                r.b_side_register[LO +: LANE_W])
            else $error("Port A not showing B register");

        chk_both_drive: assert property (
            s_ab_stored and s_ba_stored
            |=> port_a_drv.drive[g] && port_b_drv.drive[g])
            else $error("Crossed stored mode not driving both");

        chk_fresh_ab: assert property (
            s_ab_stored ##0 a_rise[g] |=> port_b_drv.value[LO +: LANE_W]
                == $past(port_a_in[LO +: LANE_W]))
            else $error("Port B missed newly stored value");

        chk_fresh_ba: assert property (
            s_ba_stored ##0 b_rise[g] |=> port_a_drv.value[LO +: LANE_W]
                == $past(port_b_in[LO +: LANE_W]))
            else $error("Port A missed newly stored value");

        chk_live_capture: assert property (
            ctl.a_to_b_drive_enable[g] && !ctl.a_to_b_source_select[g]
            && a_rise[g] |=> port_b_drv.value[LO +: LANE_W] ==
                r.a_side_register[LO +: LANE_W])
            else $error("Live transfer disturbed by capture");
    end

    chk_bus_answer: assert property (
        (avs_read || avs_write) && avs_waitrequest
        |=> !avs_waitrequest ##1 avs_waitrequest)
        else $error("Bus answer not one cycle wide");

    chk_ovf_sticky: assert property (
        r.overflow && !wr_take |=> r.overflow)
        else $error("Overflow flag lost without clear");

endmodule
`default_nettype wire

// ==== shared/rbt16_pkg.sv ====
// Purpose: Constants and carrier types for the registered bus transceiver
// Assumes: 100 MHz clk, Avalon-MM register slave with 32-bit data
// Notes: Offsets are byte addresses of aligned 32-bit words
package rbt16_pkg;

    // ==========================================================
    // Geometry
    localparam int LANES = 2;
    localparam int LANE_W = 8;
    localparam int WORD_W = 16;
    localparam int ADDR_W = 5;
    localparam int DATA_W = 32;
    localparam int MASK_W = 2 * LANES;
    localparam int LOG_W = MASK_W + 2 * WORD_W;
    localparam int FIFO_DEPTH = 16;

    // ==========================================================
    // Register offsets
    localparam logic [ADDR_W-1:0] REG_CTRL = 5'h00;
    localparam logic [ADDR_W-1:0] REG_STATUS = 5'h04;
    localparam logic [ADDR_W-1:0] REG_STORE = 5'h08;
    localparam logic [ADDR_W-1:0] REG_LOG_DATA = 5'h0C;
    localparam logic [ADDR_W-1:0] REG_LOG_MASK = 5'h10;

    // ==========================================================
    // Field positions
    localparam int CTRL_LOG_EN_BIT = 0;
    localparam int STAT_EMPTY_BIT = 0;
    localparam int STAT_FULL_BIT = 1;
    localparam int STAT_OVF_BIT = 2;
    localparam int STAT_COUNT_LSB = 4;

    // ==========================================================
    // Reset values
    localparam logic RST_WAIT = 1'h1;
    localparam logic RST_LOG_EN = 1'h0;

    // ==========================================================
    // Carrier types
    typedef struct packed {
        logic [LANES-1:0] a_to_b_drive_enable;
        logic [LANES-1:0] b_to_a_drive_enable_low;
        logic [LANES-1:0] a_capture_clock;
        logic [LANES-1:0] b_capture_clock;
        logic [LANES-1:0] a_to_b_source_select;
        logic [LANES-1:0] b_to_a_source_select;
    } rbt16_ctl_t;

    typedef struct packed {
        logic [WORD_W-1:0] value;
        logic [LANES-1:0] drive;
    } rbt16_drv_t;

    typedef struct packed {
        logic [LANES-1:0] b_mask;
        logic [LANES-1:0] a_mask;
        logic [WORD_W-1:0] b_word;
        logic [WORD_W-1:0] a_word;
    } rbt16_log_t;

endpackage

// ==== rtl/rbt16_fifo.sv ====
// Purpose: Synchronous FIFO with valid/ready on both sides
// Assumes: Single clock, synchronous active-high reset
// Notes: Memory is not reset; only pointers and count are
`timescale 1ns/10ps
`default_nettype none
module rbt16_fifo #(
    parameter int WIDTH = 36,
    parameter int DEPTH = 16
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Fill side
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic out_valid,
    input wire logic out_ready,
    output logic [WIDTH-1:0] out_data,
    // Fill level
    output logic [$clog2(DEPTH+1)-1:0] count
);
    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH+1);

    typedef struct packed {
        logic [PW-1:0] wr_ptr;
        logic [PW-1:0] rd_ptr;
        logic [CW-1:0] count;
    } rbt16_fifo_st_t;

    rbt16_fifo_st_t r;
    rbt16_fifo_st_t next_r;
    logic [WIDTH-1:0] mem [DEPTH];
    logic push;
    logic pop;

    // Handshake terms
    assign in_ready = (r.count != CW'(DEPTH));
    assign out_valid = (r.count != '0);
    assign out_data = mem[r.rd_ptr];
    assign count = r.count;
    assign push = in_valid && in_ready;
    assign pop = out_valid && out_ready;

    // Pointer and count update
    always_comb begin
        next_r = r;
        if (push) begin
            next_r.wr_ptr = PW'((r.wr_ptr + 1'b1) % DEPTH);
        end
        if (pop) begin
            next_r.rd_ptr = PW'((r.rd_ptr + 1'b1) % DEPTH);
        end
        next_r.count = CW'(r.count + CW'(push) - CW'(pop));
    end

    // State register
    always_ff @(posedge clk) begin
        if (rst) begin
            r <= '0;
        end else begin
            r <= next_r;
        end
    end

    // Storage write
    always_ff @(posedge clk) begin
        if (push) begin
            mem[r.wr_ptr] <= in_data;
        end
    end

endmodule
`default_nettype wire

// ==== verif/rbt16_bus_model.sv ====
// Purpose: Far-side model that drives and receives both buses
// Assumes: Device drive outputs change only on clk
// Notes: Undriven lanes show the inverse of their last level
`timescale 1ns/10ps
`default_nettype none
module rbt16_bus_model (
    // Clock
    input wire logic clk,
    // Bench side
    input wire logic [1:0] a_en,
    input wire logic [1:0] b_en,
    input wire logic [15:0] a_val,
    input wire logic [15:0] b_val,
    // Device side
    input wire rbt16_pkg::rbt16_drv_t a_drv,
    input wire rbt16_pkg::rbt16_drv_t b_drv,
    output logic [15:0] port_a_in,
    output logic [15:0] port_b_in
);
    import rbt16_pkg::*;
    logic [15:0] last_a;
    logic [15:0] last_b;

    // ==========================================================
    // Wire resolution
    function automatic logic [7:0] res(input logic dev, input logic bus,
        input logic [7:0] dv, input logic [7:0] bv, input logic [7:0] lv);
        if (dev && bus) begin
            return 8'hXX;
        end
        if (dev) begin
            return dv;
        end
        if (bus) begin
            return bv;
        end
        return ~lv;
    endfunction

    always_comb begin
        for (int l = 0; l < LANES; l++) begin
            port_a_in[8*l+:8] = res(a_drv.drive[l], a_en[l],
                a_drv.value[8*l+:8], a_val[8*l+:8], last_a[8*l+:8]);
            port_b_in[8*l+:8] = res(b_drv.drive[l], b_en[l],
                b_drv.value[8*l+:8], b_val[8*l+:8], last_b[8*l+:8]);
        end
    end

    // Last level seen, for released lanes
    always_ff @(posedge clk) begin
        last_a <= port_a_in;
        last_b <= port_b_in;
    end
endmodule
`default_nettype wire

// ==== verif/tb_top.sv ====
// Purpose: Self-checking bench for the registered bus transceiver
// Assumes: Design outputs registered on clk, bus answers by waitrequest
// Notes: Partner releases its lanes in the cycle of a mode change, retakes them one cycle later
`timescale 1ns/10ps
`default_nettype none
`define CHK(nm, exp, got) \
    begin n_tests++; if ((got) !== (exp)) begin fails++; \
    $display("CHECK FAILED %s exp %0h got %0h", nm, exp, got); end end
module tb_top;
    import rbt16_pkg::*;
    logic clk = 1'b0;
    logic rst;
    rbt16_ctl_t ctl;
    logic [1:0] a_en;
    logic [1:0] b_en;
    logic [15:0] a_val;
    logic [15:0] b_val;
    logic [15:0] port_a_in;
    logic [15:0] port_b_in;
    rbt16_drv_t a_drv;
    rbt16_drv_t b_drv;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read;
    logic avs_write;
    logic [DATA_W-1:0] avs_writedata;
    logic [DATA_W-1:0] avs_readdata;
    logic avs_waitrequest;
    int fails = 0;
    int n_tests = 0;
    int cyc = 0;

    // ==========================================================
    // Instances
    rbt16_core dut_u (.clk(clk), .rst(rst), .ctl(ctl),
        .port_a_in(port_a_in), .port_a_drv(a_drv),
        .port_b_in(port_b_in), .port_b_drv(b_drv),
        .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
    rbt16_bus_model bus_u (.clk(clk), .a_en(a_en), .b_en(b_en),
        .a_val(a_val), .b_val(b_val), .a_drv(a_drv), .b_drv(b_drv),
        .port_a_in(port_a_in), .port_b_in(port_b_in));

    // Clock and hang guard
    always #5 clk = ~clk;
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 5000) begin
            fails++;
            stop_test();
        end
    end

    // ==========================================================
    // Shared tasks
    task automatic stop_test();
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    // Mode change: partner lets go, then takes its lanes
    task automatic setp(input logic [1:0] ab, bal, sab, sba, ae, be,
        input logic [15:0] av, bv);
        @(posedge clk);
        ctl.a_to_b_drive_enable <= ab;
        ctl.b_to_a_drive_enable_low <= bal;
        ctl.a_to_b_source_select <= sab;
        ctl.b_to_a_source_select <= sba;
        a_en <= 2'h0;
        b_en <= 2'h0;
        @(posedge clk);
        a_en <= ae;
        b_en <= be;
        a_val <= av;
        b_val <= bv;
        @(posedge clk);
        #1;
    endtask

    // One capture pulse, one cycle high
    task automatic cap(input logic [1:0] ca, cb, input logic [15:0] av, bv);
        @(posedge clk);
        ctl.a_capture_clock <= ca;
        ctl.b_capture_clock <= cb;
        a_val <= av;
        b_val <= bv;
        @(posedge clk);
        ctl.a_capture_clock <= 2'h0;
        ctl.b_capture_clock <= 2'h0;
        #1;
    endtask

    // Avalon access, held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [ADDR_W-1:0] a,
        input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q);
        @(posedge clk);
        avs_address <= a;
        avs_writedata <= d;
        avs_write <= wr;
        avs_read <= !wr;
        forever begin
            @(posedge clk);
            if (avs_waitrequest === 1'b0) break;
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask

    // ==========================================================
    // Scenarios
    task automatic t_iso();
        logic [31:0] q;
        setp(2'h0, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 16'h1111, 16'h2222);
        `CHK("iso a drive", 2'h0, a_drv.drive);
        `CHK("iso b drive", 2'h0, b_drv.drive);
        cap(2'h3, 2'h3, 16'h1111, 16'h2222);
        `CHK("iso cap b drive", 2'h0, b_drv.drive);
        bus(1'b0, REG_STORE, 32'h0, q);
        `CHK("both stored", 32'h22221111, q);
    endtask

    task automatic t_ab();
        logic [31:0] q;
        setp(2'h3, 2'h3, 2'h0, 2'h0, 2'h3, 2'h0, 16'h1234, 16'h0);
        `CHK("ab b drive", 2'h3, b_drv.drive);
        `CHK("ab b live", 16'h1234, b_drv.value);
        `CHK("ab a drive", 2'h0, a_drv.drive);
        cap(2'h3, 2'h0, 16'h5A5A, 16'h0);
        `CHK("ab live cap", 16'h5A5A, b_drv.value);
        bus(1'b0, REG_STORE, 32'h0, q);
        `CHK("ab a reg", 16'h5A5A, q[15:0]);
        setp(2'h3, 2'h3, 2'h3, 2'h0, 2'h3, 2'h0, 16'h0F0F, 16'h0);
        `CHK("ab stored", 16'h5A5A, b_drv.value);
        cap(2'h3, 2'h0, 16'h0F0F, 16'h0);
        `CHK("ab new stored", 16'h0F0F, b_drv.value);
    endtask

    task automatic t_ba();
        setp(2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 2'h3, 16'h0, 16'hC3C3);
        `CHK("ba a drive", 2'h3, a_drv.drive);
        `CHK("ba a live", 16'hC3C3, a_drv.value);
        `CHK("ba b drive", 2'h0, b_drv.drive);
        setp(2'h0, 2'h0, 2'h0, 2'h3, 2'h0, 2'h3, 16'h0, 16'h3C3C);
        `CHK("ba stored", 16'h2222, a_drv.value);
        cap(2'h0, 2'h3, 16'h0, 16'h3C3C);
        `CHK("ba new stored", 16'h3C3C, a_drv.value);
    endtask

    task automatic t_both();
        // Both live: each port drives the other back
        setp(2'h3, 2'h0, 2'h0, 2'h0, 2'h0, 2'h0, 16'h0, 16'h0);
        `CHK("loop a drive", 2'h3, a_drv.drive);
        `CHK("loop b drive", 2'h3, b_drv.drive);
        setp(2'h3, 2'h0, 2'h3, 2'h3, 2'h0, 2'h0, 16'h0, 16'h0);
        `CHK("both a drive", 2'h3, a_drv.drive);
        `CHK("both b drive", 2'h3, b_drv.drive);
        `CHK("both a value", 16'h3C3C, a_drv.value);
        `CHK("both b value", 16'h0F0F, b_drv.value);
        cap(2'h3, 2'h3, 16'h0, 16'h0);
        `CHK("swap a value", 16'h0F0F, a_drv.value);
        `CHK("swap b value", 16'h3C3C, b_drv.value);
    endtask

    task automatic t_lanes();
        setp(2'h1, 2'h1, 2'h0, 2'h0, 2'h1, 2'h2, 16'h0077, 16'h9900);
        `CHK("lane a drive", 2'h2, a_drv.drive);
        `CHK("lane b drive", 2'h1, b_drv.drive);
        `CHK("lane0 b", 8'h77, b_drv.value[7:0]);
        `CHK("lane1 a", 8'h99, a_drv.value[15:8]);
    endtask

    task automatic t_log();
        logic [31:0] q;
        logic [15:0] k;
        setp(2'h0, 2'h3, 2'h0, 2'h0, 2'h3, 2'h3, 16'h0, 16'h5555);
        bus(1'b0, REG_CTRL, 32'h0, q);
        `CHK("ctrl reset", 32'h0, q);
        bus(1'b0, REG_STATUS, 32'h0, q);
        `CHK("status reset", 32'h1, q);
        bus(1'b1, 5'h14, 32'hFFFFFFFF, q);
        bus(1'b0, 5'h14, 32'h0, q);
        `CHK("unmapped", 32'h0, q);
        bus(1'b1, REG_CTRL, 32'h1, q);
        bus(1'b0, REG_CTRL, 32'h0, q);
        `CHK("ctrl rw", 32'h1, q);
        // Seventeen captures into sixteen places
        k = 16'h0100;
        repeat (17) begin
            cap(2'h3, 2'h0, k, 16'h5555);
            k = k + 16'h1;
        end
        bus(1'b0, REG_STATUS, 32'h0, q);
        `CHK("full ovf", 32'h106, q);
        bus(1'b0, REG_LOG_MASK, 32'h0, q);
        `CHK("log mask", 32'h3, q);
        bus(1'b1, REG_STATUS, 32'h4, q);
        bus(1'b0, REG_STATUS, 32'h0, q);
        `CHK("ovf clear", 32'h102, q);
        k = 16'h0100;
        repeat (16) begin
            bus(1'b0, REG_LOG_DATA, 32'h0, q);
            `CHK("log data", {16'h0F0F, k}, q);
            k = k + 16'h1;
        end
        bus(1'b0, REG_STATUS, 32'h0, q);
        `CHK("drained", 32'h1, q);
        bus(1'b0, REG_LOG_DATA, 32'h0, q);
        `CHK("empty pop", 32'h0, q);
    endtask

    // ==========================================================
    // Main sequence
    initial begin
        rst = 1'b1;
        ctl = '0;
        ctl.b_to_a_drive_enable_low = 2'h3;
        // Captures in reset give the unreset storage a known value
        ctl.a_capture_clock = 2'h3;
        ctl.b_capture_clock = 2'h3;
        a_en = 2'h3;
        b_en = 2'h3;
        a_val = 16'h0;
        b_val = 16'h0;
        avs_address = '0;
        avs_read = 1'b0;
        avs_write = 1'b0;
        avs_writedata = '0;
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        ctl.a_capture_clock <= 2'h0;
        ctl.b_capture_clock <= 2'h0;
        a_en <= 2'h0;
        b_en <= 2'h0;
        t_iso();
        t_ab();
        t_ba();
        t_both();
        t_lanes();
        t_log();
        stop_test();
    end
endmodule
`default_nettype wire
